// File: design/esmdc_pkg.sv
// Constants for the extended SMRAM decode control block
package esmdc_pkg;
    localparam logic [7:0]  ESMDC_REG_OFFSET    = 8'h73;
    localparam logic [7:0]  ESMDC_REG_RESET     = 8'h3f;
    localparam int          ESMDC_HIGH_EN_BIT   = 7;
    localparam int          ESMDC_RSVD_BIT      = 6;
    localparam int          ESMDC_POLICY_BIT    = 5;
    localparam int          ESMDC_L1_BIT        = 4;
    localparam int          ESMDC_L2_BIT        = 3;
    localparam int          ESMDC_SIZE_HI_BIT   = 2;
    localparam int          ESMDC_SIZE_LO_BIT   = 1;
    localparam int          ESMDC_TSEG_EN_BIT   = 0;
    localparam logic        ESMDC_HIGH_EN_RESET = 1'h0;
    localparam logic [1:0]  ESMDC_SIZE_896K     = 2'h3;
    localparam logic [1:0]  ESMDC_SIZE_RESET    = 2'h3;
    localparam logic [31:0] ESMDC_LEGACY_LO     = 32'h000a0000;
    localparam logic [31:0] ESMDC_LEGACY_HI     = 32'h000bffff;
    // Offsets above top of memory
    localparam logic [31:0] ESMDC_OFS_896K      = 32'h000e0000;
    localparam logic [31:0] ESMDC_OFS_1M        = 32'h00100000;
    localparam logic [31:0] ESMDC_TSEG_BYTES    = 32'h000e0000;
endpackage

// File: design/esmdc_decode.sv
// Address decoder for legacy, high and T segment SMRAM windows
module esmdc_decode
    import esmdc_pkg::*;
(
    input  wire logic        global_smram_enable_i,
    input  wire logic        high_region_enable_i,
    input  wire logic        top_segment_enable_i,
    input  wire logic [1:0]  top_segment_size_i,
    input  wire logic        smm_active_i,
    input  wire logic [31:0] top_of_memory_i,
    input  wire logic [31:0] mem_addr_i,
    output logic             smram_hit_o,
    output logic             forward_pci_o,
    output logic             private_claim_o
);
    import esmdc_pkg::*;

    typedef struct packed {
        logic in_legacy;
        logic in_high;
        logic in_tseg;
        logic compat_on;
        logic high_on;
        logic tseg_on;
    } esmdc_dec_t;

    esmdc_dec_t dec;

    // Inclusive low bound, exclusive high bound
    function automatic logic esmdc_in(input logic [31:0] a,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
        esmdc_in = (a >= lo) && (a < hi);
    endfunction

    function automatic logic [31:0] esmdc_size_bytes(input logic [1:0] s);
        esmdc_size_bytes = (s == ESMDC_SIZE_896K) ? ESMDC_TSEG_BYTES : 32'h0;
    endfunction

    always_comb begin
        dec.in_legacy = (mem_addr_i >= ESMDC_LEGACY_LO)
                     && (mem_addr_i <= ESMDC_LEGACY_HI);
        dec.in_high   = esmdc_in(mem_addr_i,
                                 top_of_memory_i + ESMDC_OFS_896K,
                                 top_of_memory_i + ESMDC_OFS_1M);
        dec.in_tseg   = esmdc_in(mem_addr_i,
                                 top_of_memory_i + ESMDC_OFS_896K
                                 - esmdc_size_bytes(top_segment_size_i),
                                 top_of_memory_i + ESMDC_OFS_896K);
        dec.compat_on = global_smram_enable_i && !high_region_enable_i;
        dec.high_on   = global_smram_enable_i && high_region_enable_i;
        dec.tseg_on   = global_smram_enable_i && top_segment_enable_i;
        smram_hit_o   = smm_active_i && ((dec.compat_on && dec.in_legacy)
                     || (dec.high_on && dec.in_high)
                     || (dec.tseg_on && dec.in_tseg));
        forward_pci_o = dec.in_legacy
                     && !(smm_active_i && dec.compat_on);
        // Memory handed over as T segment or high region is not claimed
        private_claim_o = (mem_addr_i >= top_of_memory_i)
                       && !(dec.tseg_on && dec.in_tseg)
                       && !(dec.high_on && dec.in_high);
    end
endmodule

// File: design/esmdc_top.sv
// Extended SMRAM control register and the decode it steers
// Notes on behaviour
// RL1: Global and high enables both set select the high region over compat.
// RL2: In high mode the legacy A0000h-BFFFFh window goes to the PCI bus.
// RL3: In high mode SMM accesses at TOP_OF_MEMORY+896K up to TOP_OF_MEMORY+1MB hit SMRAM.
// RL4: Global set with high clear serves compat SMRAM at A0000h-BFFFFh.
// RL5: Once locked, high enable and T segment size ignore writes.
// RL6: Bit 5 always reads 1 for write-back policy and cannot be written.
// RL7: Bits 4 and 3 always read 1 as read-only cacheability flags.
// RL8: The size field at bits 2:1 reads 11 for 896K; other codes reserved.
// RL9: The T segment spans TOP_OF_MEMORY+896K minus its size up to TOP_OF_MEMORY+896K.
// RL10: Private memory handed over as T segment is no longer claimed.
// RL11: Global and T segment enables both set make the T region visible.
// RL12: The T segment enable at bit 0 always holds 1.
// RL13: T segment plus high region give one contiguous 1MB SMRAM space.
// RL14: Global enable clear disables every SMM region.
// RL15: The lock is set by software and cleared only by power-on reset.
// RL16: Reset value is 3Fh; reserved bit 6 reads 0 and ignores writes.
module esmdc_top
    import esmdc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [7:0]  cfg_wdata_i,
    output logic      [7:0]  cfg_rdata_o,
    input  wire logic        global_smram_enable_i,
    input  wire logic        smm_space_lock_i,
    input  wire logic        smm_active_i,
    input  wire logic [31:0] top_of_memory_i,
    input  wire logic [31:0] mem_addr_i,
    output logic             smram_hit_o,
    output logic             forward_pci_o,
    output logic             private_claim_o,
    output logic             high_region_enable_o
);
    import esmdc_pkg::*;

    typedef struct packed {
        logic       high_region_enable;
        logic [1:0] top_segment_size;
        logic [7:0] rdata;
    } esmdc_state_t;

    esmdc_state_t state;
    esmdc_state_t next_state;
    logic         sel;
    logic [7:0]   image;

    function automatic logic [7:0] esmdc_image(input logic       hi,
                                               input logic [1:0] sz);
        logic [7:0] v;
        v = 8'h00;
        v[ESMDC_HIGH_EN_BIT] = hi;
        v[ESMDC_RSVD_BIT]    = 1'h0;                  // see RL16
        v[ESMDC_POLICY_BIT]  = 1'h1;                  // see RL6
        v[ESMDC_L1_BIT]      = 1'h1;                  // see RL7
        v[ESMDC_L2_BIT]      = 1'h1;                  // see RL7
        v[ESMDC_SIZE_HI_BIT:ESMDC_SIZE_LO_BIT] = sz;  // see RL8
        v[ESMDC_TSEG_EN_BIT] = 1'h1;                  // see RL12
        esmdc_image = v;
    endfunction

    assign sel   = (cfg_addr_i == ESMDC_REG_OFFSET);
    assign image = esmdc_image(state.high_region_enable,
                               state.top_segment_size);

    always_comb begin
        next_state = state;
        // Lock is owned by the neighbouring register and held till reset
        if (cfg_wr_i && sel && !smm_space_lock_i) begin  // see RL5, RL15
            next_state.high_region_enable = cfg_wdata_i[ESMDC_HIGH_EN_BIT];
            // Reserved size codes leave the field unchanged
            if (cfg_wdata_i[ESMDC_SIZE_HI_BIT:ESMDC_SIZE_LO_BIT]
                == ESMDC_SIZE_896K) begin                // see RL8
                next_state.top_segment_size = ESMDC_SIZE_896K;
            end
        end
        if (cfg_rd_i && sel) begin
            next_state.rdata = image;
        end else begin
            next_state.rdata = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin                               // see RL16
            state.high_region_enable <= ESMDC_HIGH_EN_RESET;
            state.top_segment_size   <= ESMDC_SIZE_RESET;
            state.rdata              <= 8'h00;
        end else begin
            state <= next_state;
        end
    end

    assign cfg_rdata_o          = state.rdata;
    assign high_region_enable_o = state.high_region_enable;

    // see RL1, RL2, RL3, RL4, RL9, RL10, RL11, RL13, RL14
    esmdc_decode u_decode (
        .global_smram_enable_i (global_smram_enable_i),
        .high_region_enable_i  (state.high_region_enable),
        .top_segment_enable_i  (image[ESMDC_TSEG_EN_BIT]),
        .top_segment_size_i    (state.top_segment_size),
        .smm_active_i          (smm_active_i),
        .top_of_memory_i       (top_of_memory_i),
        .mem_addr_i            (mem_addr_i),
        .smram_hit_o           (smram_hit_o),
        .forward_pci_o         (forward_pci_o),
        .private_claim_o       (private_claim_o)
    );

    // Helper views of the address for the checks below
    logic in_legacy_a;
    logic in_high_a;
    logic in_tseg_a;
    assign in_legacy_a = (mem_addr_i >= ESMDC_LEGACY_LO)
                      && (mem_addr_i <= ESMDC_LEGACY_HI);
    assign in_high_a = (mem_addr_i >= top_of_memory_i + ESMDC_OFS_896K)
                    && (mem_addr_i < top_of_memory_i + ESMDC_OFS_1M);
    assign in_tseg_a = (mem_addr_i >= top_of_memory_i)
                    && (mem_addr_i < top_of_memory_i + ESMDC_OFS_896K);

    AST_RESET_VALUE: assert property ( // see RL16
        @(posedge clk_i)
        $past(reset_i) |-> image == ESMDC_REG_RESET)
        else $error("register image not 3Fh after reset");

    AST_LOCK_FREEZE: assert property ( // see RL5
        @(posedge clk_i) disable iff (reset_i)
        smm_space_lock_i |=> $stable(image))
        else $error("locked register changed");

    AST_WRITE_TAKEN: assert property ( // see RL5
        @(posedge clk_i) disable iff (reset_i)
        cfg_wr_i && sel && !smm_space_lock_i
        |=> state.high_region_enable == $past(cfg_wdata_i[7]))
        else $error("unlocked write to high enable lost");

    AST_FIXED_BITS: assert property ( // see RL6
        @(posedge clk_i) disable iff (reset_i)
        image[6:0] == 7'h3f)
        else $error("fixed bits do not read 0111111");

    AST_READ_DATA: assert property ( // see RL7
        @(posedge clk_i) disable iff (reset_i)
        cfg_rd_i && sel |=> cfg_rdata_o == $past(image)
                            && cfg_rdata_o[5:3] == 3'h7)
        else $error("read data wrong");

    AST_UNMAPPED_READ: assert property ( // see RL8
        @(posedge clk_i) disable iff (reset_i)
        cfg_rd_i && !sel |=> cfg_rdata_o == 8'h00)
        else $error("read of other offset not zero");

    AST_HIGH_MODE: assert property ( // see RL1
        @(posedge clk_i) disable iff (reset_i)
        global_smram_enable_i && state.high_region_enable && smm_active_i
        |-> (smram_hit_o == (in_high_a || in_tseg_a))
            && !(in_legacy_a && smram_hit_o))
        else $error("high mode decode wrong");

    AST_HIGH_FWD: assert property ( // see RL2
        @(posedge clk_i) disable iff (reset_i)
        global_smram_enable_i && state.high_region_enable && in_legacy_a
        |-> forward_pci_o && !smram_hit_o)
        else $error("legacy window not forwarded in high mode");

    AST_HIGH_HIT: assert property ( // see RL3
        @(posedge clk_i) disable iff (reset_i)
        global_smram_enable_i && state.high_region_enable && smm_active_i
        && in_high_a |-> smram_hit_o && !private_claim_o)
        else $error("high window not decoded");

    AST_COMPAT: assert property ( // see RL4
        @(posedge clk_i) disable iff (reset_i)
        global_smram_enable_i && !state.high_region_enable && in_legacy_a
        |-> smram_hit_o == smm_active_i
            && forward_pci_o == !smm_active_i)
        else $error("compat window decode wrong");

    AST_TSEG: assert property ( // see RL11
        @(posedge clk_i) disable iff (reset_i)
        global_smram_enable_i && smm_active_i && in_tseg_a
        |-> smram_hit_o)
        else $error("T segment not visible");

    AST_TSEG_SPAN: assert property ( // see RL9
        @(posedge clk_i) disable iff (reset_i)
        global_smram_enable_i && smm_active_i && !state.high_region_enable
        && (mem_addr_i >= top_of_memory_i)
        |-> smram_hit_o == in_tseg_a)
        else $error("T segment bounds wrong");

    AST_PRIVATE: assert property ( // see RL10
        @(posedge clk_i) disable iff (reset_i)
        global_smram_enable_i && in_tseg_a |-> !private_claim_o)
        else $error("handed over memory still claimed");

    AST_CONTIG: assert property ( // see RL13
        @(posedge clk_i) disable iff (reset_i)
        global_smram_enable_i && state.high_region_enable && smm_active_i
        && (mem_addr_i >= top_of_memory_i)
        && (mem_addr_i < top_of_memory_i + ESMDC_OFS_1M)
        |-> smram_hit_o)
        else $error("1MB SMRAM space not contiguous");

    AST_GLOBAL_OFF: assert property ( // see RL14
        @(posedge clk_i) disable iff (reset_i)
        !global_smram_enable_i |-> !smram_hit_o
                                   && (forward_pci_o == in_legacy_a))
        else $error("SMRAM hit with global enable clear");

    AST_LOCK_HELD: assert property ( // see RL15
        @(posedge clk_i) disable iff (reset_i)
        smm_space_lock_i && cfg_wr_i && sel
        |=> state.high_region_enable == $past(state.high_region_enable))
        else $error("write passed the lock");

    // Read data stands for one cycle only
    AST_READ_IDLE: assert property ( // see RL16
        @(posedge clk_i) disable iff (reset_i)
        !cfg_rd_i |=> cfg_rdata_o == 8'h00)
        else $error("read data stood longer than one cycle");

    AST_SIZE_KEPT: assert property ( // see RL8
        @(posedge clk_i) disable iff (reset_i)
        state.top_segment_size == ESMDC_SIZE_896K)
        else $error("T segment size left its only legal code");
endmodule

// File: verification/esmdc_cpu_model.sv
// Processor side model issuing memory accesses and counting PCI forwards
module esmdc_cpu_model (
    input  wire logic        clk_i,
    input  wire logic        forward_pci_i,
    output logic      [31:0] mem_addr_o,
    output logic             smm_active_o,
    output logic      [31:0] top_of_memory_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int pci_count;
    initial begin
        mem_addr_o = 32'h00000000;
        smm_active_o = 1'b0;
        top_of_memory_o = 32'h01000000;
        pci_count = 0;
    end
    // Access launched at an edge; a forward is counted once it has settled
    task automatic access(input logic [31:0] top_of_memory, input logic [31:0] a,
                          input logic smm);
        @(posedge clk_i);
        top_of_memory_o <= top_of_memory;
        mem_addr_o <= a;
        smm_active_o <= smm;
        #1;
        if (forward_pci_i === 1'b1) begin
            pci_count++;
        end
    endtask
endmodule

// File: verification/extended_smram_decode_control_bench.sv
// Self-checking bench for the extended SMRAM decode control block
module extended_smram_decode_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import esmdc_pkg::*;
    logic clk_i, reset_i, cfg_wr_i, cfg_rd_i, glob, lock;
    logic [7:0] cfg_addr_i, cfg_wdata_i, rdata;
    logic [31:0] addr, top_of_memory;
    logic smm, hit, fwd, claim, high_o, hexp;
    logic [2:0] e;
    int failures, compares, nfwd;
    esmdc_top uut (.clk_i(clk_i), .reset_i(reset_i), .cfg_wr_i(cfg_wr_i),
        .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(rdata),
        .global_smram_enable_i(glob), .smm_space_lock_i(lock),
        .smm_active_i(smm), .top_of_memory_i(top_of_memory), .mem_addr_i(addr),
        .smram_hit_o(hit), .forward_pci_o(fwd), .private_claim_o(claim),
        .high_region_enable_o(high_o));
    esmdc_cpu_model cpu (.clk_i(clk_i), .forward_pci_i(fwd),
        .mem_addr_o(addr), .smm_active_o(smm), .top_of_memory_o(top_of_memory));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cfg_write(input logic [7:0] d);
        @(posedge clk_i);
        cfg_wr_i <= 1'b1;
        cfg_wdata_i <= d;
        cfg_addr_i <= ESMDC_REG_OFFSET;
        @(posedge clk_i);
        cfg_wr_i <= 1'b0;
        if (lock === 1'b0) hexp = d[7];
    endtask
    task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        cfg_rd_i <= 1'b1;
        cfg_addr_i <= a;
        @(posedge clk_i);
        cfg_rd_i <= 1'b0;
        #1 d = rdata;
    endtask
    // Expected {hit, forward, claim} for one access
    function automatic logic [2:0] dec(input logic [31:0] a, t,
                                       input logic g, h, s);
        logic lg, hi, ts;
        logic [31:0] off;
        off = a - t;
        lg = a >= ESMDC_LEGACY_LO && a <= ESMDC_LEGACY_HI;
        hi = a >= t && off >= ESMDC_OFS_896K && off < ESMDC_OFS_1M;
        ts = a >= t && off < ESMDC_TSEG_BYTES;
        return {s & g & ((lg & !h) | (h & hi) | ts), lg & !(s & g & !h),
                (a >= t) & !(g & ts) & !(g & h & hi)};
    endfunction
    initial begin
        #(40 * 20000);
        failures++;
        summarize();
    end
    initial begin
        logic [7:0] d;
        logic [31:0] t, a;
        reset_i = 1'b1;
        {cfg_wr_i, cfg_rd_i, glob, lock, hexp} = '0;
        cfg_addr_i = 8'h00;
        cfg_wdata_i = 8'h00;
        void'($urandom(32'ha389));
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        cfg_read(ESMDC_REG_OFFSET, d);
        chk(d, ESMDC_REG_RESET);
        cfg_read(8'h72, d);
        chk(d, 8'h00);
        for (int b = 0; b < 40; b++) begin
            @(posedge clk_i);
            lock <= ($urandom_range(0, 3) == 0);
            glob <= ($urandom_range(0, 4) != 0);
            cfg_write(b < 2 ? 8'hff : 8'($urandom));
            cfg_read(ESMDC_REG_OFFSET, d);
            chk(d, {hexp, 7'h3f});
            chk({7'h0, high_o}, {7'h0, hexp});
            for (int k = 0; k < 12; k++) begin
                t = {4'h0, 4'($urandom), 24'h0} + 32'h01000000;
                case (k % 3)
                    0: a = 32'h0009ffff + $urandom_range(0, 32'h20001);
                    1: a = t - 1 + $urandom_range(0, 32'h100001);
                    default: a = $urandom;
                endcase
                cpu.access(t, a, 1'($urandom));
                #1 e = dec(addr, top_of_memory, glob, hexp, smm);
                nfwd += e[1];
                chk({7'h0, hit}, {7'h0, e[2]});
                chk({7'h0, fwd}, {7'h0, e[1]});
                chk({7'h0, claim}, {7'h0, e[0]});
            end
        end
        chk(8'(cpu.pci_count - nfwd), 8'h00);
        @(posedge clk_i);
        lock <= 1'b0;
        cfg_write(8'h80);
        #1 chk({7'h0, high_o}, 8'h01);
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        hexp = 1'b0;
        cfg_read(ESMDC_REG_OFFSET, d);
        chk(d, ESMDC_REG_RESET);
        chk({7'h0, high_o}, 8'h00);
        summarize();
    end
endmodule
